// *** pkg/adcc_regs.vh ***
// Register map, field positions, reset values and timing counts of the converter control block.
// ------------------------------------------------------------------
// Operation
// ------------------------------------------------------------------
// Operation
// - Select bits 7..3 make port B pin 3 and port A pins 7..4 analog channels 7..3.
// - Select bits 2..0 make port B pins 2..0 analog channels 2..0.
// - A conversion starts only after start goes high then low again.
// - Busy flag sets once a conversion starts; software cannot write it.
// - Busy flag clears when the conversion finishes.
// - Conversion end sets the converter interrupt request flag.
// - An enabled, set request flag raises the converter interrupt.
// - Converter clock is system clock divided by two to the divider code.
// - Converter is powered only while the power enable bit is high.
// - Reference select 01 takes the supply rail, else the external pin.
// - Reference pin function enable disables the pin's other shared functions.
// - A conversion lasts 4 sampling plus 12 converting converter clocks.
// - Justify bit 0 left-aligns, 1 right-aligns the result; unused bits zero.
// - Result registers keep their contents while the converter is disabled; a completion in the first unpowered cycle still loads them.
// - Channel codes 0..7 route a channel; codes 8..15 leave input floating.
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// ------------------------------------------------------------------
// Byte addresses
// ------------------------------------------------------------------
`define ADCC_OFS_CTRL0      8'h00
`define ADCC_OFS_CTRL1      8'h04
`define ADCC_OFS_PINSEL     8'h08
`define ADCC_OFS_RES_HI     8'h0C
`define ADCC_OFS_RES_LO     8'h10
`define ADCC_OFS_INTCTL     8'h14

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ADCC_C0_START       7
`define ADCC_C0_BUSY        6
`define ADCC_C0_PWR         5
`define ADCC_C0_JUST        4
`define ADCC_IC_ENABLE      0
`define ADCC_IC_REQ         1

// ------------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------------
`define ADCC_RST_BYTE       8'h00
`define ADCC_REF_SUPPLY     2'h1
`define ADCC_SAMPLE_CLKS    5'h04
`define ADCC_CONV_CLKS      5'h0C

`endif

// *** logic/adcc_top.v ***
// Converter control block: AHB-Lite registers, clock divider, conversion sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.vh"

module adcc_top #(
    parameter RES_W = 12
) (
    // Clock and reset
    input  wire                 hclk,
    input  wire                 hresetn,
    // AHB-Lite slave
    input  wire                 hsel,
    input  wire [7:0]           haddr,
    input  wire [1:0]           htrans,
    input  wire                 hwrite,
    input  wire [2:0]           hsize,
    input  wire [31:0]          hwdata,
    input  wire                 hready,
    output wire [31:0]          hrdata,
    output wire                 hreadyout,
    output wire                 hresp,
    // Analog core
    output wire                 conv_power_en,
    output wire                 conv_clock_en,
    output wire                 conv_sampling,
    output wire [7:0]           analog_channel_n,
    output wire                 external_input_floating,
    output wire                 ref_from_supply,
    output wire                 ref_pin_analog,
    input  wire [RES_W-1:0]     conv_result,
    // Pin overrides
    output wire                 port_b_pin_3_analog,
    output wire                 port_b_pin_2_analog,
    output wire                 port_b_pin_1_analog,
    output wire                 port_b_pin_0_analog,
    output wire                 port_a_pin_7_analog,
    output wire                 port_a_pin_6_analog,
    output wire                 port_a_pin_5_analog,
    output wire                 port_a_pin_4_analog,
    // Interrupt
    output wire                 conv_irq
);

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    localparam ST_IDLE   = 2'd0;
    localparam ST_SAMPLE = 2'd1;
    localparam ST_CONV   = 2'd2;

    reg  [7:0]       converter_control_0_q;
    reg  [7:0]       converter_control_1_q;
    reg  [7:0]       analog_pin_select_q;
    reg  [7:0]       result_high_byte_q;
    reg  [7:0]       result_low_byte_q;
    reg              irq_enable_q;
    reg              irq_req_q;
    reg              busy_q;
    reg  [1:0]       state_q;
    reg  [4:0]       cyc_q;
    reg  [6:0]       div_q;
    reg              start_armed_q;
    reg  [RES_W-1:0] res_sync1_q;
    reg  [RES_W-1:0] res_sync2_q;
    reg              dph_q;
    reg              dph_wr_q;
    reg  [7:0]       dph_addr_q;
    reg  [31:0]      hrdata_q;

    wire [2:0] div_sel = converter_control_1_q[2:0];
    wire [1:0] ref_sel = converter_control_1_q[4:3];
    wire [3:0] ext_sel = converter_control_0_q[3:0];
    wire       pwr     = converter_control_0_q[`ADCC_C0_PWR];
    wire       start   = converter_control_0_q[`ADCC_C0_START];
    wire       justify = converter_control_0_q[`ADCC_C0_JUST];

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Writes land in the data phase; the slave never inserts wait states.
    wire addr_ok = hsel && htrans[1] && hready;
    wire wr_c0   = dph_q && dph_wr_q && (dph_addr_q == `ADCC_OFS_CTRL0);
    wire wr_c1   = dph_q && dph_wr_q && (dph_addr_q == `ADCC_OFS_CTRL1);
    wire wr_ps   = dph_q && dph_wr_q && (dph_addr_q == `ADCC_OFS_PINSEL);
    wire wr_ic   = dph_q && dph_wr_q && (dph_addr_q == `ADCC_OFS_INTCTL);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    reg [31:0] rd_d;
    always @*
    begin
        rd_d = 32'h0000_0000;
        case (haddr)
            `ADCC_OFS_CTRL0:  rd_d[7:0] = {converter_control_0_q[7], busy_q,
                                           converter_control_0_q[5:0]};
            `ADCC_OFS_CTRL1:  rd_d[7:0] = converter_control_1_q;
            `ADCC_OFS_PINSEL: rd_d[7:0] = analog_pin_select_q;
            `ADCC_OFS_RES_HI: rd_d[7:0] = result_high_byte_q;
            `ADCC_OFS_RES_LO: rd_d[7:0] = result_low_byte_q;
            `ADCC_OFS_INTCTL: rd_d[1:0] = {irq_req_q, irq_enable_q};
            default:          rd_d = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_q      <= 1'b0;
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
            hrdata_q   <= 32'h0000_0000;
        end
        else
        begin
            dph_q      <= addr_ok;
            dph_wr_q   <= addr_ok && hwrite;
            dph_addr_q <= haddr;
            if (addr_ok && !hwrite)
                hrdata_q <= rd_d;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            converter_control_0_q <= `ADCC_RST_BYTE;
            converter_control_1_q <= `ADCC_RST_BYTE;
            analog_pin_select_q   <= `ADCC_RST_BYTE;
            irq_enable_q          <= 1'b0;
        end
        else
        begin
            if (wr_c0)
                converter_control_0_q <= hwdata[7:0];
            if (wr_c1)
                converter_control_1_q <= hwdata[7:0];
            if (wr_ps)
                analog_pin_select_q <= hwdata[7:0];
            if (wr_ic)
                irq_enable_q <= hwdata[`ADCC_IC_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // Pin and reference steering
    // ------------------------------------------------------------------
    assign port_b_pin_3_analog = analog_pin_select_q[7];
    assign port_a_pin_7_analog = analog_pin_select_q[6];
    assign port_a_pin_6_analog = analog_pin_select_q[5];
    assign port_a_pin_5_analog = analog_pin_select_q[4];
    assign port_a_pin_4_analog = analog_pin_select_q[3];
    assign port_b_pin_2_analog = analog_pin_select_q[2];
    assign port_b_pin_1_analog = analog_pin_select_q[1];
    assign port_b_pin_0_analog = analog_pin_select_q[0];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_chan
            assign analog_channel_n[gi] = !ext_sel[3] && (ext_sel[2:0] == gi);
        end
    endgenerate
    assign external_input_floating = ext_sel[3];

    assign ref_from_supply = (ref_sel == `ADCC_REF_SUPPLY);
    // The pin only becomes a reference input when the external source is chosen.
    assign ref_pin_analog  = !ref_from_supply;
    assign conv_power_en   = pwr;

    // ------------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------------
    // A one-cycle enable at hclk / 2^code replaces a derived clock.
    wire [6:0] div_mask = (7'h7F >> (3'd7 - div_sel));
    wire       tick     = ((div_q & div_mask) == div_mask);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_q <= 7'h00;
        else if (state_q == ST_IDLE)
            div_q <= 7'h00;
        else
            div_q <= div_q + 7'h01;
    end
    // Gating with power silences the core at once, a cycle before the sequencer idles.
    assign conv_clock_en = tick && (state_q != ST_IDLE) && pwr;
    assign conv_sampling = (state_q == ST_SAMPLE) && pwr;

    // ------------------------------------------------------------------
    // Result synchroniser
    // ------------------------------------------------------------------
    // The analog core is asynchronous to hclk, so its result passes two stages.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            res_sync1_q <= {RES_W{1'b0}};
            res_sync2_q <= {RES_W{1'b0}};
        end
        else
        begin
            res_sync1_q <= conv_result;
            res_sync2_q <= res_sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // Start detector
    // ------------------------------------------------------------------
    // The high level arms a conversion and its removal launches it.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            start_armed_q <= 1'b0;
        else
            start_armed_q <= start;
    end

    wire start_fall = start_armed_q && !start;
    wire conv_done  = (state_q == ST_CONV) && tick && (cyc_q == `ADCC_CONV_CLKS - 5'h01);

    // ------------------------------------------------------------------
    // Interrupt request flag
    // ------------------------------------------------------------------
    // Set wins over a software clear in the same cycle, so no completion is lost.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_req_q <= 1'b0;
        else if (conv_done)
            irq_req_q <= 1'b1;
        else if (wr_ic && !hwdata[`ADCC_IC_REQ])
            irq_req_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Result formatter and result bytes
    // ------------------------------------------------------------------
    // Unused positions are forced to zero so either byte can be read alone.
    reg [7:0] result_high_byte_d;
    reg [7:0] result_low_byte_d;
    always @*
    begin
        if (justify)
        begin
            result_high_byte_d = {4'h0, res_sync2_q[11:8]};
            result_low_byte_d  = res_sync2_q[7:0];
        end
        else
        begin
            result_high_byte_d = res_sync2_q[11:4];
            result_low_byte_d  = {res_sync2_q[3:0], 4'h0};
        end
    end

    // Both bytes load only on completion; conv_done is not gated by power, so it can still load them in the first unpowered cycle.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            result_high_byte_q <= `ADCC_RST_BYTE;
            result_low_byte_q  <= `ADCC_RST_BYTE;
        end
        else if (conv_done)
        begin
            result_high_byte_q <= result_high_byte_d;
            result_low_byte_q  <= result_low_byte_d;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            cyc_q   <= 5'h00;
            busy_q  <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start_fall && pwr)
                    begin
                        state_q <= ST_SAMPLE;
                        cyc_q   <= 5'h00;
                        busy_q  <= 1'b1;
                    end
                end
                ST_SAMPLE:
                begin
                    if (tick)
                    begin
                        if (cyc_q == `ADCC_SAMPLE_CLKS - 5'h01)
                        begin
                            state_q <= ST_CONV;
                            cyc_q   <= 5'h00;
                        end
                        else
                            cyc_q <= cyc_q + 5'h01;
                    end
                end
                ST_CONV:
                begin
                    if (conv_done)
                    begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                    else if (tick)
                        cyc_q <= cyc_q + 5'h01;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
            // Dropping power returns the sequencer to idle, but a conv_done in the first unpowered cycle still loads the results.
            if (!pwr && state_q != ST_IDLE)
            begin
                state_q <= ST_IDLE;
                busy_q  <= 1'b0;
            end
        end
    end

    assign conv_irq = irq_enable_q && irq_req_q;

endmodule // adcc_top
`default_nettype wire

// *** testbench/adcc_checker.sv ***
// Port-level assertions for the converter control block.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.vh"
module adcc_checker (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    // Converter side
    input wire logic        conv_power_en,
    input wire logic        conv_clock_en,
    input wire logic        conv_sampling,
    input wire logic [7:0]  analog_channel_n,
    input wire logic        external_input_floating,
    input wire logic        ref_from_supply,
    input wire logic        ref_pin_analog,
    input wire logic        port_b_pin_3_analog,
    input wire logic        port_b_pin_2_analog,
    input wire logic        port_b_pin_1_analog,
    input wire logic        port_b_pin_0_analog,
    input wire logic        port_a_pin_7_analog,
    input wire logic        port_a_pin_6_analog,
    input wire logic        port_a_pin_5_analog,
    input wire logic        port_a_pin_4_analog,
    input wire logic        conv_irq
);
    // ------------------------------------------------------------------
    // Data-phase tracking
    // ------------------------------------------------------------------
    logic       dp_q;
    logic [7:0] da_q;
    logic       st_q;
    logic       fall_q;
    logic [4:0] scnt_q;
    wire        wr_c0  = dp_q && da_q == `ADCC_OFS_CTRL0;
    wire        wr_c1  = dp_q && da_q == `ADCC_OFS_CTRL1;
    wire        wr_pin = dp_q && da_q == `ADCC_OFS_PINSEL;
    wire        wr_ic  = dp_q && da_q == `ADCC_OFS_INTCTL;
    wire [7:0]  pins   = {port_b_pin_3_analog, port_a_pin_7_analog, port_a_pin_6_analog,
                          port_a_pin_5_analog, port_a_pin_4_analog, port_b_pin_2_analog,
                          port_b_pin_1_analog, port_b_pin_0_analog};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_q   <= 1'b0;
            da_q   <= 8'h00;
            st_q   <= 1'b0;
            fall_q <= 1'b0;
            scnt_q <= 5'h00;
        end
        else
        begin
            dp_q   <= hsel & htrans[1] & hready & hwrite;
            da_q   <= haddr;
            fall_q <= wr_c0 & st_q & ~hwdata[7] & hwdata[5];
            if (wr_c0)
                st_q <= hwdata[7];
            scnt_q <= !conv_sampling ? 5'h00 : scnt_q + {4'h0, conv_clock_en};
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_pin_hi; wr_pin |=> pins[7:3] == $past(hwdata[7:3]); endproperty
    a_pin_hi: assert property (p_pin_hi) else $error("upper pin select wrong");
    property p_pin_lo; wr_pin |=> pins[2:0] == $past(hwdata[2:0]); endproperty
    a_pin_lo: assert property (p_pin_lo) else $error("lower pin select wrong");
    property p_chan;
        wr_c0 |=> external_input_floating == $past(hwdata[3]) && analog_channel_n ==
            ($past(hwdata[3]) ? 8'h00 : 8'h01 << $past(hwdata[2:0]));
    endproperty
    a_chan: assert property (p_chan) else $error("channel route wrong");
    property p_ref;
        wr_c1 |=> ref_from_supply == ($past(hwdata[4:3]) == 2'h1) && ref_pin_analog != ref_from_supply;
    endproperty
    a_ref: assert property (p_ref) else $error("reference source wrong");
    property p_pwr; wr_c0 |=> conv_power_en == $past(hwdata[5]); endproperty
    a_pwr: assert property (p_pwr) else $error("power enable wrong");
    property p_pwr_use; conv_sampling || conv_clock_en |-> conv_power_en; endproperty
    a_pwr_use: assert property (p_pwr_use) else $error("activity while unpowered");
    property p_samp; $fell(conv_sampling) && conv_power_en |-> scnt_q == 5'h04; endproperty
    a_samp: assert property (p_samp) else $error("sampling length wrong");
    property p_start; $rose(conv_sampling) |-> fall_q || $past(fall_q) || $past(fall_q, 2); endproperty
    a_start: assert property (p_start) else $error("conversion without start fall");
    property p_irq_off; wr_ic && !hwdata[0] |=> !conv_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
    c_conv: cover property ($fell(conv_sampling));
    c_irq: cover property ($rose(conv_irq));
    c_float: cover property (external_input_floating);
endmodule // adcc_checker
`default_nettype wire

// *** testbench/adcc_analog_model.sv ***
// Behavioural analog core that returns a bench-set level, marked by the routed channel.
`timescale 1ns/100ps
`default_nettype none
module adcc_analog_model (
    // Controls from the block
    input  wire logic        conv_power_en,
    input  wire logic [7:0]  analog_channel_n,
    // Level applied by the bench
    input  wire logic [11:0] level,
    // Result towards the block
    output logic      [11:0] conv_result
);
    // An unpowered or floating input shows the inverse, so stale data cannot pass as fresh.
    assign conv_result = (conv_power_en && analog_channel_n != 8'h00) ?
                         level ^ {4'h0, analog_channel_n} : ~level;
endmodule // adcc_analog_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.vh"
module tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [11:0] level = 12'hB4E;
    logic [31:0] rd;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire  [11:0] conv_result;
    wire  [7:0]  chan;
    wire  [7:0]  pins;
    wire         pwr, clk_en, float, ref_sup, ref_pin, irq, resp;
    int          num_errors = 0;
    int          tests_run = 0;
    int          pulses = 0;
    int          gap_cnt = 0;
    int          last_gap = 0;
    always #10 hclk = ~hclk;
    adcc_top uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(resp), .conv_power_en(pwr),
        .conv_clock_en(clk_en), .conv_sampling(), .analog_channel_n(chan),
        .external_input_floating(float), .ref_from_supply(ref_sup), .ref_pin_analog(ref_pin),
        .conv_result(conv_result), .port_b_pin_3_analog(pins[7]), .port_a_pin_7_analog(pins[6]),
        .port_a_pin_6_analog(pins[5]), .port_a_pin_5_analog(pins[4]),
        .port_a_pin_4_analog(pins[3]), .port_b_pin_2_analog(pins[2]),
        .port_b_pin_1_analog(pins[1]), .port_b_pin_0_analog(pins[0]), .conv_irq(irq));
    adcc_analog_model u_core (.conv_power_en(pwr), .analog_channel_n(chan), .level(level),
        .conv_result(conv_result));
    always @(posedge hclk)
    begin
        gap_cnt <= clk_en ? 1 : gap_cnt + 1;
        if (clk_en)
        begin
            pulses   <= pulses + 1;
            last_gap <= gap_cnt;
        end
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits for the given line, or for ready when none is asked, under a bound.
    task automatic wait_on(input bit on_irq, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while ((on_irq ? irq : hreadyout) !== 1'b1 && n < lim);
        if (n >= lim)
        begin
            num_errors++;
            wrap_up;
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_on(1'b0, 64);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        wait_on(1'b0, 64);
        rd = hrdata;
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [2:0]  d;
        logic [7:0]  c0;
        logic [11:0] v;
        int          p0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a <= 8'h18; a += 4)
        begin
            ahb(1'b0, a[7:0], 32'h0);
            check(rd, 32'h0);
            check({31'h0, resp}, 32'h0);
        end
        ahb(1'b1, `ADCC_OFS_PINSEL, 32'hA5);
        ahb(1'b0, `ADCC_OFS_PINSEL, 32'h0);
        check(rd, 32'hA5);
        check({24'h0, pins}, 32'hA5);
        ahb(1'b1, `ADCC_OFS_PINSEL, 32'h5A);
        #1;
        check({24'h0, pins}, 32'h5A);
        for (int r = 0; r < 4; r++)
        begin
            ahb(1'b1, `ADCC_OFS_CTRL1, 32'(r) << 3);
            #1;
            check({30'h0, ref_pin, ref_sup}, (r == 1) ? 32'h1 : 32'h2);
        end
        for (int c = 0; c < 16; c++)
        begin
            ahb(1'b1, `ADCC_OFS_CTRL0, 32'(c));
            #1;
            check({23'h0, float, chan}, (c < 8) ? 32'h1 << c : 32'h100);
        end
        ahb(1'b1, `ADCC_OFS_INTCTL, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 3'h5 : (i == 1) ? 3'h6 : 3'h7;
            c0 = {2'b00, 1'b1, i[0], 1'b0, d};
            ahb(1'b1, `ADCC_OFS_CTRL1, {29'h0, d});
            ahb(1'b1, `ADCC_OFS_CTRL0, {24'h0, c0 | 8'h80});
            repeat (20) @(posedge hclk);
            ahb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
            check(rd, {24'h0, c0 | 8'h80});
            p0 = pulses;
            ahb(1'b1, `ADCC_OFS_CTRL0, {24'h0, c0});
            ahb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
            check(rd, {24'h0, c0 | 8'h40});
            wait_on(1'b1, 4000);
            check(32'(pulses - p0), 32'd16);
            check(32'(last_gap), 32'h1 << d);
            ahb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
            check(rd, {24'h0, c0});
            v = level ^ (12'h1 << d);
            ahb(1'b0, `ADCC_OFS_RES_HI, 32'h0);
            check(rd, i[0] ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
            ahb(1'b0, `ADCC_OFS_RES_LO, 32'h0);
            check(rd, i[0] ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
            ahb(1'b0, `ADCC_OFS_INTCTL, 32'h0);
            check(rd, 32'h3);
            check({31'h0, irq}, 32'h1);
            ahb(1'b1, `ADCC_OFS_INTCTL, 32'h2);
            #1;
            check({31'h0, irq}, 32'h0);
            ahb(1'b1, `ADCC_OFS_INTCTL, 32'h1);
            ahb(1'b0, `ADCC_OFS_INTCTL, 32'h0);
            check(rd, 32'h1);
        end
        ahb(1'b1, `ADCC_OFS_CTRL0, 32'h0);
        level <= 12'h123;
        #1;
        check({31'h0, pwr}, 32'h0);
        repeat (4) @(posedge hclk);
        ahb(1'b0, `ADCC_OFS_RES_HI, 32'h0);
        check(rd, {24'h0, v[11:4]});
        wrap_up;
    end
endmodule // tb_top
bind adcc_top adcc_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .conv_power_en(conv_power_en),
    .conv_clock_en(conv_clock_en), .conv_sampling(conv_sampling),
    .analog_channel_n(analog_channel_n), .external_input_floating(external_input_floating),
    .ref_from_supply(ref_from_supply), .ref_pin_analog(ref_pin_analog),
    .port_b_pin_3_analog(port_b_pin_3_analog), .port_b_pin_2_analog(port_b_pin_2_analog),
    .port_b_pin_1_analog(port_b_pin_1_analog), .port_b_pin_0_analog(port_b_pin_0_analog),
    .port_a_pin_7_analog(port_a_pin_7_analog), .port_a_pin_6_analog(port_a_pin_6_analog),
    .port_a_pin_5_analog(port_a_pin_5_analog), .port_a_pin_4_analog(port_a_pin_4_analog),
    .conv_irq(conv_irq));
`default_nettype wire
